// *** design/pin_sync.sv ***
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ns
module pin_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    pin_sync_if.sync  pins
);
    port_a_pin_latch_pkg::byte_t stage1;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage1      <= 8'h00;
            pins.synced <= 8'h00;
        end else begin
            stage1      <= pins.raw;
            pins.synced <= stage1;
        end
    end
endmodule // pin_sync

// *** design/pin_sync_if.sv ***
// Raw and synchronised pin levels between the port and its synchroniser
`timescale 1ns/1ns
interface pin_sync_if;
    port_a_pin_latch_pkg::byte_t raw;
    port_a_pin_latch_pkg::byte_t synced;
    modport port (output raw, input synced);
    modport sync (input raw, output synced);
endinterface

// *** design/port_a_gpio.sv ***
// Port A general purpose I/O with shared comparator, reference and osc pins
`timescale 1ns/1ns
`include "port_a_pin_latch_params.svh"
module port_a_gpio (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    input  wire logic       cmp1_out,
    input  wire logic       cmp2_out,
    output logic      [3:0] cmp_in_gnd,
    output logic      [3:0] cmp_in_sel,
    output logic            vref_on_pin,
    output logic            timer0_external_clock_in,
    output logic            input_buf_en
);
    port_a_pin_latch_pkg::byte_t  port_a_pin_latch;
    port_a_pin_latch_pkg::byte_t  port_a_direction;
    port_a_pin_latch_pkg::cmp_mode_t comparator_control;
    logic [1:0]        voltage_reference_control;
    logic              osc_claims_67;
    port_a_pin_latch_pkg::byte_t  pin_view;
    port_a_pin_latch_pkg::byte_t  next_oe;
    port_a_pin_latch_pkg::byte_t  next_out;
    port_a_pin_latch_pkg::byte_t  analog_mask;

    pin_sync_if sync_bus ();
    assign sync_bus.raw = pin_in;

    pin_sync u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pins     (sync_bus)
    );

    // Which pins act as comparator analog inputs in a given mode
    function automatic port_a_pin_latch_pkg::byte_t analog_pins(
        input port_a_pin_latch_pkg::cmp_mode_t mode);
        analog_pins = 8'h00;
        if (mode == `PORT_A_PIN_LATCH_CMP_OFF)
            analog_pins = 8'h00;
        else if (mode == `PORT_A_PIN_LATCH_CMP_OUTPUTS)
            analog_pins = 8'h07;
        else
            analog_pins = 8'h0f;
    endfunction

    always_comb begin
        analog_mask = analog_pins(comparator_control);
        pin_view = sync_bus.synced & ~analog_mask;
        if (osc_claims_67)
            pin_view[7:6] = 2'b00;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            port_a_pin_latch <= `PORT_A_PIN_LATCH_LATCH_RESET;
        end else if (wr && addr == `PORT_A_PIN_LATCH_ADDR_DATA) begin
            // Sampled pins are masked to zero, so only the written byte is stored
            port_a_pin_latch <= (pin_view & 8'h00) | wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            port_a_direction <= `PORT_A_PIN_LATCH_DIR_RESET;
        end else if (wr && addr == `PORT_A_PIN_LATCH_ADDR_DIR) begin
            port_a_direction <= wdata | 8'h20;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            comparator_control        <= `PORT_A_PIN_LATCH_CMP_RESET;
            voltage_reference_control <= 2'b00;
            osc_claims_67             <= 1'b0;
        end else if (wr) begin
            if (addr == `PORT_A_PIN_LATCH_ADDR_CMP)
                comparator_control <= wdata[2:0];
            else if (addr == `PORT_A_PIN_LATCH_ADDR_VREF)
                voltage_reference_control <= wdata[7:6];
            else if (addr == `PORT_A_PIN_LATCH_ADDR_OSC)
                osc_claims_67 <= wdata[0];
        end
    end

    always_comb begin
        next_out = port_a_pin_latch;
        next_oe  = ~port_a_direction;
        if (comparator_control == `PORT_A_PIN_LATCH_CMP_OUTPUTS) begin
            next_out[3] = cmp1_out;
            next_out[4] = cmp2_out;
        end
        // Open drain: drive only a low
        next_oe[`PORT_A_PIN_LATCH_BIT_OD] = next_oe[`PORT_A_PIN_LATCH_BIT_OD]
                                 & ~next_out[`PORT_A_PIN_LATCH_BIT_OD];
        next_out[`PORT_A_PIN_LATCH_BIT_OD] = 1'b0;
        next_oe[`PORT_A_PIN_LATCH_BIT_IN_ONLY] = 1'b0;
        if (osc_claims_67)
            next_oe[7:6] = 2'b00;
        if (voltage_reference_control[1] && voltage_reference_control[0])
            next_oe[2] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_out <= 8'h00;
            pin_oe  <= 8'h00;
        end else begin
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_in_gnd   <= 4'hf;
            cmp_in_sel   <= 4'h0;
            vref_on_pin  <= 1'b0;
            input_buf_en <= 1'b0;
            timer0_external_clock_in <= 1'b0;
        end else begin
            cmp_in_sel   <= analog_mask[3:0];
            cmp_in_gnd   <= ~analog_mask[3:0];
            vref_on_pin  <= voltage_reference_control[1]
                            & voltage_reference_control[0];
            input_buf_en <= 1'b1;
            timer0_external_clock_in <=
                sync_bus.synced[`PORT_A_PIN_LATCH_BIT_OD];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == `PORT_A_PIN_LATCH_ADDR_DATA)
                rdata <= pin_view;
            else if (addr == `PORT_A_PIN_LATCH_ADDR_DIR)
                rdata <= port_a_direction;
            else if (addr == `PORT_A_PIN_LATCH_ADDR_CMP)
                rdata <= {5'h00, comparator_control};
            else if (addr == `PORT_A_PIN_LATCH_ADDR_VREF)
                rdata <= {voltage_reference_control, 6'h00};
            else if (addr == `PORT_A_PIN_LATCH_ADDR_OSC)
                rdata <= {7'h00, osc_claims_67};
            else
                rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // port_a_gpio

// *** design/port_a_pin_latch_params.svh ***
// Offsets, reset values and field positions of the port block
`ifndef PORT_A_PIN_LATCH_PARAMS_SVH
`define PORT_A_PIN_LATCH_PARAMS_SVH
`define PORT_A_PIN_LATCH_ADDR_DATA    8'h05
`define PORT_A_PIN_LATCH_ADDR_DIR     8'h85
`define PORT_A_PIN_LATCH_ADDR_CMP     8'h1f
`define PORT_A_PIN_LATCH_ADDR_VREF    8'h9f
`define PORT_A_PIN_LATCH_ADDR_OSC     8'h90
`define PORT_A_PIN_LATCH_DIR_RESET    8'hff
`define PORT_A_PIN_LATCH_LATCH_RESET  8'h00
`define PORT_A_PIN_LATCH_CMP_RESET    3'h0
`define PORT_A_PIN_LATCH_CMP_OFF      3'h7
`define PORT_A_PIN_LATCH_CMP_OUTPUTS  3'h6
`define PORT_A_PIN_LATCH_VREF_EN_BIT  7
`define PORT_A_PIN_LATCH_VREF_OE_BIT  6
`define PORT_A_PIN_LATCH_BIT_OD       4
`define PORT_A_PIN_LATCH_BIT_IN_ONLY  5
`endif

// *** design/port_a_pin_latch_pkg.sv ***
// Types shared by the port block
package port_a_pin_latch_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] cmp_mode_t;
endpackage

// *** verif/pin_model.sv ***
// Pin lines with pull-ups and an outside driver
`timescale 1ns/1ns
module pin_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    output logic     [7:0] pin_in
);
    // Pull-up, so a released line never keeps its old level
    assign pin_in = (pin_oe & pin_out)
                    | (~pin_oe & ((ext_oe & ext_val) | ~ext_oe));
endmodule // pin_model

// *** verif/port_a_gpio_properties.sv ***
// Checker for the port block
`timescale 1ns/1ns
module port_a_gpio_properties (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [3:0] cmp_in_gnd,
    input wire logic       input_buf_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence dir_wr; wr && addr == 8'h85; endsequence
    sequence dat_wr; wr && addr == 8'h05; endsequence
    sequence held_rst; !rstn ##1 !rstn; endsequence
    a_bit5_undriven: assert property (!pin_oe[5])
        else $error("bit 5 driven");
    a_od_pull_low: assert property (pin_out[4] == 1'b0)
        else $error("bit 4 drives high");
    a_dir_to_oe: assert property (dir_wr |-> ##2
        pin_oe[1:0] == ~$past(wdata[1:0], 2)) else $error("oe wrong");
    a_latch_to_pin: assert property (dat_wr |-> ##2
        pin_out[1:0] == $past(wdata[1:0], 2)) else $error("drive wrong");
    a_reset_state: assert property (disable iff (1'b0) held_rst |->
        pin_oe == 8'h00 && cmp_in_gnd == 4'hf && !input_buf_en)
        else $error("reset state wrong");
    a_buf_after_rst: assert property ($past(rstn) |-> input_buf_en)
        else $error("input buffer off");
    a_rdata_on_read: assert property (rdata != 8'h00 |-> $past(rd))
        else $error("stray read data");
    a_dir5_reads_one: assert property (rd && addr == 8'h85 |=> rdata[5])
        else $error("direction bit 5 low");
endmodule // port_a_gpio_properties
bind port_a_gpio port_a_gpio_properties u_props (.*);

// *** verif/tb_port_a_gpio.sv ***
// Register and pin tests for the port block
`timescale 1ns/1ns
module tb_port_a_gpio;
    logic       core_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       cmp1_out = 1'b0, cmp2_out = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ext_oe = 8'h00, ext_val = 8'h00;
    logic [7:0] rdata, pin_in, pin_out, pin_oe;
    logic [3:0] cmp_in_gnd, cmp_in_sel;
    logic       vref_on_pin, timer0_external_clock_in;
    int         miscompares = 0, checks_done = 0;
    always #4 core_clk = ~core_clk;
    port_a_gpio DUT (.*, .input_buf_en());
    pin_model PM (.*);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // Covers output register plus two synchroniser stages
    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        check(pin_oe, 8'h00);
        rchk(8'h85, 8'hff);
        settle();
        rchk(8'h05, 8'hf0);
        wreg(8'h1f, 8'h07);
        wreg(8'h90, 8'h00);
        ext_oe <= 8'h20;
        wreg(8'h85, 8'h00);
        wreg(8'h05, 8'ha5);
        settle();
        check(pin_oe, 8'hdf);
        check(pin_out & pin_oe, 8'h85);
        rchk(8'h05, 8'h85);
        ext_val <= 8'h20;
        wreg(8'h05, 8'h5a);
        settle();
        check(pin_oe, 8'hcf);
        check({6'h00, vref_on_pin, timer0_external_clock_in}, 8'h01);
        rchk(8'h05, 8'h7a);
        ext_oe <= 8'hff;
        ext_val <= 8'h3c;
        wreg(8'h85, 8'hff);
        settle();
        check(pin_oe, 8'h00);
        rchk(8'h05, 8'h3c);
        ext_oe <= 8'h00;
        wreg(8'h90, 8'h01);
        wreg(8'h85, 8'h00);
        settle();
        check(pin_oe & 8'hc0, 8'h00);
        rchk(8'h05, 8'h3a);
        cmp1_out <= 1'b1;
        wreg(8'h1f, 8'h06);
        settle();
        check(pin_oe & pin_out & 8'h08, 8'h08);
        check(pin_oe & 8'h1f, 8'h1f);
        check({cmp_in_sel, cmp_in_gnd}, 8'h78);
        rchk(8'h05, 8'h28);
        wreg(8'h85, 8'h24);
        wreg(8'h9f, 8'hc0);
        settle();
        check({6'h00, vref_on_pin, timer0_external_clock_in}, 8'h02);
        rstn <= 1'b0;
        @(posedge core_clk);
        #1 check(pin_oe, 8'h00);
        tally_and_finish();
    end
endmodule // tb_port_a_gpio
